// ==== secure_page_pkg.sv ====
/*
 * Constants, types and ECC helpers for the secure page access block.
 * Assumes a single 100 MHz system clock; serial pins arrive asynchronously.
 */
// Function
// RQ1: array words hold four data bytes plus six parity bits, 38 bits total.
// RQ2: each read word is checked and a single bad bit corrected before shifting out.
// RQ3: every write rewrites the whole four-byte word and recomputes its parity.
// RQ4: during a write cycle busy reads 1 and the ready poll returns ffh.
// RQ5: after the write cycle busy reads 0 and the ready poll returns 00h.
// RQ6: while busy, only status read and ready poll are accepted.
// RQ7: host polls status or ready until ready before issuing a new command.
// RQ8: 512-byte area: lower 256 bytes read-only, upper 256 programmable and lockable.
// RQ9: bytes 0h-fh return the 128-bit serial number, read like other data.
// RQ10: secure read is 83h plus 24-bit address with A10 low; later input ignored.
// RQ11: secure read auto-increments and wraps from 1ffh to 000h while selected.
// RQ12: secure write uses 82h with A10 low and A8 high, byte or page.
// RQ13: legacy mode blocks secure writes when both block-protect bits are set.
// RQ14: after locking, every secure write command is ignored.
// RQ15: select released off a byte boundary aborts the secure write.
// RQ16: lock ignored when protect-enable is set and write-protect pin asserted.
// RQ17: lock permanently makes the whole secure area read-only; here rst_b clears page_locked and the area becomes writable again.
// RQ18: host sends write enable before the lock command.
// RQ19: lock is 82h, address with A10 high, confirm byte bit 1 set.
// RQ20: select released before all 40 lock bits aborts the lock.
// RQ21: lock check (83h, A10 high) returns bit 0 set when locked.
// RQ22: completing a write cycle clears the write enable latch.
// RQ23: status read 05h returns 16 bits; volatile bits refresh each byte.
// RQ24: programming starts only after select rises on a complete byte with enable set.
// RQ25: ready poll opcode and write duration are design parameters.
// RQ26: A10 selects read versus lock check, and page write versus lock.
package secure_page_pkg;

   // ==========================================================
   // opcodes
   localparam logic [7:0] OP_STATUS_READ  = 8'h05;
   localparam logic [7:0] OP_SECURE_READ  = 8'h83;
   localparam logic [7:0] OP_SECURE_WRITE = 8'h82;
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_READY_POLL   = 8'h08;

   // ==========================================================
   // field positions and values
   localparam int         ADDR_SEL_BIT  = 10;
   localparam int         ADDR_PAGE_BIT = 8;
   localparam int         CONF_BIT      = 1;
   localparam int         SERIAL_BYTES  = 16;
   localparam logic [1:0] BP_ALL        = 2'b11;
   localparam logic [7:0] POLL_BUSY     = 8'hff;
   localparam logic [7:0] POLL_READY    = 8'h00;
   localparam logic [31:0] ERASED_DATA  = 32'hffff_ffff;

   // ==========================================================
   // timing
   localparam int WRITE_TIME_NS    = 1000;
   localparam int CLK_PERIOD_NS    = 10;
   localparam int WRITE_CYCLES_DEF = (WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // ==========================================================
   // types
   typedef struct packed {
      logic cs_b;
      logic sck;
      logic si;
   } spi_pins_t;

   typedef struct packed {
      logic       protect_mode;
      logic       protect_enable_bit;
      logic [1:0] block_protect_bits;
   } prot_cfg_t;

   localparam spi_pins_t PINS_IDLE = '{cs_b: 1'b1, sck: 1'b0, si: 1'b0};

   typedef enum logic [5:0] {
      ST_IDLE    = 6'h01,
      ST_OPCODE  = 6'h02,
      ST_ADDR    = 6'h04,
      ST_RX_DATA = 6'h08,
      ST_TX_DATA = 6'h10,
      ST_IGNORE  = 6'h20
   } seq_state_t;

   // ==========================================================
   // ecc: hamming code, parity at positions 1,2,4,8,16,32 of 38
   function automatic logic [37:0] ecc_encode(input logic [31:0] d);
      logic [37:0] cw;
      int          k;
      cw = '0;
      k  = 0;
      for (int i = 1; i <= 38; i++) begin
         if ((i & (i - 1)) != 0) begin
            cw[i-1] = d[k];
            k++;
         end
      end
      for (int p = 0; p < 6; p++) begin
         for (int i = 1; i <= 38; i++) begin
            if (((i >> p) & 1) == 1 && i != (1 << p)) begin
               cw[(1<<p)-1] = cw[(1<<p)-1] ^ cw[i-1];
            end
         end
      end
      return cw;
   endfunction

   function automatic logic [31:0] ecc_correct(input logic [37:0] c);
      logic [37:0] cw;
      logic [5:0]  syn;
      logic [31:0] d;
      int          k;
      cw  = c;
      syn = '0;
      d   = '0;
      k   = 0;
      for (int i = 1; i <= 38; i++) begin
         if (cw[i-1]) begin
            syn = syn ^ 6'(i);
         end
      end
      if (syn != 6'h00 && syn <= 6'd38) begin
         cw[syn-6'd1] = ~cw[syn-6'd1];
      end
      for (int i = 1; i <= 38; i++) begin
         if ((i & (i - 1)) != 0) begin
            d[k] = cw[i-1];
            k++;
         end
      end
      return d;
   endfunction

   localparam logic [37:0] ERASED_CW = ecc_encode(ERASED_DATA);

endpackage

// ==== secure_page_ecc_access.sv ====
/*
 * Serial command logic of the secure page area: ecc-protected storage,
 * secure read/write/lock/lock-check, status read and ready polling.
 * Assumes serial pins and the write-protect pin are asynchronous to clk_sys
 * and the serial clock is much slower (mode 0); protection settings come
 * from logic on clk_sys.
 */
`timescale 1ns/100ps
module secure_page_ecc_access
   import secure_page_pkg::*;
#(
   parameter logic [127:0] SERIAL_NUMBER   = 128'h0123_4567_89ab_cdef_0f1e_2d3c_4b5a_6978, // arbitrary
   parameter logic [7:0]   WRITE_ENABLE_OP = OP_WRITE_ENABLE,
   parameter logic [7:0]   READY_POLL_OP   = OP_READY_POLL,
   parameter int           WRITE_CYCLES    = WRITE_CYCLES_DEF
) (
   // clock and reset
   input  logic      clk_sys,
   input  logic      rst_b,
   // serial pins
   input  spi_pins_t spi_in,
   output logic      so,
   output logic      so_oe_b,
   // protection settings
   input  prot_cfg_t prot,
   input  logic      wp_b,
   // state
   output logic      busy_flag,
   output logic      write_enable_latch,
   output logic      page_locked
);

   // ==========================================================
   // pin synchronisers
   spi_pins_t pin_s1, pin_s2;
   logic      wp_s1, wp_s2, sck_d, cs_d;

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pin_s1 <= PINS_IDLE;
         pin_s2 <= PINS_IDLE;
         wp_s1  <= 1'b1;
         wp_s2  <= 1'b1;
         sck_d  <= 1'b0;
         cs_d   <= 1'b1;
      end else begin
         pin_s1 <= spi_in;
         pin_s2 <= pin_s1;
         wp_s1  <= wp_b;
         wp_s2  <= wp_s1;
         sck_d  <= pin_s2.sck;
         cs_d   <= pin_s2.cs_b;
      end
   end

   // ==========================================================
   // state
   seq_state_t  state, next_state;
   logic [2:0]  bit_cnt, next_bit_cnt;
   logic [1:0]  byte_cnt, next_byte_cnt;
   logic [7:0]  rx_sr, next_rx, opcode, next_opcode, tx_sr, next_tx, pg_ptr, next_pg_ptr;
   logic [23:0] addr, next_addr;
   logic [8:0]  rd_addr, next_rd_addr;
   logic        next_so, next_so_oe_b, st_hi, next_st_hi, data_seen, next_data_seen;
   logic        conf_ok, next_conf, next_wel, next_busy, next_locked, lock_cyc, next_lock_cyc;
   prot_cfg_t   snap, next_snap;
   logic [31:0] wr_cnt, next_wr_cnt;
   logic [6:0]  word_idx, next_word_idx;
   logic [255:0] pmask, next_pmask;
   logic [63:0] wvalid, next_wvalid;
   logic        pbuf_we, mem_we;

   logic [37:0] mem [0:63];
   logic [7:0]  pbuf [0:255];

   wire         sck_rise  = pin_s2.sck & ~sck_d & ~pin_s2.cs_b;
   wire         sck_fall  = ~pin_s2.sck & sck_d & ~pin_s2.cs_b;
   wire         cs_rise   = pin_s2.cs_b & ~cs_d;
   wire         byte_done = (bit_cnt == 3'd7);
   wire [7:0]   rx_next   = {rx_sr[6:0], pin_s2.si};
   wire [23:0]  full_addr = {addr[15:0], rx_next};
   wire         op_end    = sck_rise && byte_done && state == ST_OPCODE;
   wire         addr_end  = sck_rise && byte_done && state == ST_ADDR && byte_cnt == 2'd2;
   wire [7:0]   stat0     = {snap.protect_enable_bit, 3'b000, snap.block_protect_bits,
                             write_enable_latch, busy_flag};
   wire [7:0]   stat1     = {snap.protect_mode, 7'h00};
   wire [7:0]   poll_byte = busy_flag ? POLL_BUSY : POLL_READY;
   wire [7:0]   lock_byte = {7'h00, page_locked};

   // ==========================================================
   // read path: fetch word, correct, pick byte
   logic [8:0]  look_addr;
   logic [31:0] rom_data, rd_data, old_data, merged;
   logic [37:0] raw_cw;
   logic [7:0]  rd_byte;

   always_comb begin
      look_addr = addr_end ? full_addr[8:0] : rd_addr;
      for (int b = 0; b < 4; b++) begin
         rom_data[b*8 +: 8] = 8'h00;
         if (int'(look_addr[7:2]) * 4 + b < SERIAL_BYTES) begin
            rom_data[b*8 +: 8] = SERIAL_NUMBER[(15 - int'(look_addr[7:2]) * 4 - b) * 8 +: 8]; // [RQ9]
         end
      end
      if (look_addr[ADDR_PAGE_BIT]) begin
         raw_cw = wvalid[look_addr[7:2]] ? mem[look_addr[7:2]] : ERASED_CW;
      end else begin
         raw_cw = ecc_encode(rom_data); // [RQ8]
      end
      rd_data = ecc_correct(raw_cw); // [RQ2]
      rd_byte = rd_data[look_addr[1:0]*8 +: 8];
   end

   // ==========================================================
   // write path: merge buffered bytes into whole words
   always_comb begin
      old_data = ecc_correct(wvalid[word_idx[5:0]] ? mem[word_idx[5:0]] : ERASED_CW);
      for (int b = 0; b < 4; b++) begin
         merged[b*8 +: 8] = pmask[{word_idx[5:0], 2'(b)}] ? pbuf[{word_idx[5:0], 2'(b)}]
                                                           : old_data[b*8 +: 8]; // [RQ3]
      end
      mem_we = busy_flag && !lock_cyc && !word_idx[6] && (|pmask[{word_idx[5:0], 2'b00} +: 4]);
   end

   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem[word_idx[5:0]] <= ecc_encode(merged); // [RQ1] [RQ3]
      end
      if (pbuf_we) begin
         pbuf[pg_ptr] <= rx_next;
      end
   end

   // ==========================================================
   // command sequencer and write cycle
   always_comb begin
      next_state     = state;
      next_bit_cnt   = bit_cnt;
      next_byte_cnt  = byte_cnt;
      next_rx        = rx_sr;
      next_opcode    = opcode;
      next_addr      = addr;
      next_rd_addr   = rd_addr;
      next_tx        = tx_sr;
      next_so        = so;
      next_so_oe_b   = so_oe_b;
      next_st_hi     = st_hi;
      next_pg_ptr    = pg_ptr;
      next_data_seen = data_seen;
      next_conf      = conf_ok;
      next_snap      = (state == ST_TX_DATA) ? snap : prot;
      next_wel       = write_enable_latch;
      next_busy      = busy_flag;
      next_locked    = page_locked;
      next_lock_cyc  = lock_cyc;
      next_wr_cnt    = wr_cnt;
      next_word_idx  = word_idx;
      next_pmask     = pmask;
      next_wvalid    = wvalid;
      pbuf_we        = 1'b0;
      if (busy_flag) begin
         if (!word_idx[6]) begin
            next_word_idx = word_idx + 7'd1;
         end
         if (wr_cnt == 32'd0) begin
            next_busy = 1'b0; // [RQ5]
            next_wel  = 1'b0; // [RQ22]
            if (lock_cyc) begin
               next_locked = 1'b1; // [RQ17]
            end
         end else begin
            next_wr_cnt = wr_cnt - 32'd1;
         end
      end
      if (mem_we) begin
         next_wvalid[word_idx[5:0]] = 1'b1;
      end
      if (pin_s2.cs_b) begin
         next_state   = ST_IDLE;
         next_so_oe_b = 1'b1;
         // start only on a whole byte with data seen and, for a lock, the confirm bit set
         if (cs_rise && state == ST_RX_DATA && bit_cnt == 3'd0 && data_seen
             && (!addr[ADDR_SEL_BIT] || conf_ok)) begin // [RQ15] [RQ19] [RQ20] [RQ24]
            next_busy     = 1'b1; // [RQ4]
            next_wr_cnt   = 32'(WRITE_CYCLES - 1);
            next_word_idx = 7'd0;
            next_lock_cyc = addr[ADDR_SEL_BIT]; // [RQ26]
         end
      end else if (state == ST_IDLE) begin
         next_state    = ST_OPCODE;
         next_bit_cnt  = 3'd0;
         next_byte_cnt = 2'd0;
      end else if (sck_rise) begin
         next_rx      = rx_next;
         next_bit_cnt = bit_cnt + 3'd1;
         if (byte_done) begin
            unique case (state)
               ST_OPCODE: begin
                  next_opcode = rx_next;
                  next_state  = ST_IGNORE;
                  if (busy_flag && rx_next != OP_STATUS_READ && rx_next != READY_POLL_OP) begin
                     next_state = ST_IGNORE; // [RQ6]
                  end else if (rx_next == OP_STATUS_READ) begin
                     next_tx    = stat0; // [RQ23]
                     next_st_hi = 1'b1;
                     next_state = ST_TX_DATA;
                  end else if (rx_next == READY_POLL_OP) begin
                     next_tx    = poll_byte; // [RQ4] [RQ5] [RQ25]
                     next_state = ST_TX_DATA;
                  end else if (rx_next == WRITE_ENABLE_OP) begin
                     next_wel = 1'b1;
                  end else if (rx_next == OP_SECURE_READ || rx_next == OP_SECURE_WRITE) begin
                     next_state    = ST_ADDR;
                     next_byte_cnt = 2'd0;
                  end
               end
               ST_ADDR: begin
                  next_addr     = full_addr;
                  next_byte_cnt = byte_cnt + 2'd1;
                  if (byte_cnt == 2'd2) begin
                     if (opcode == OP_SECURE_READ) begin
                        next_state   = ST_TX_DATA; // [RQ10]
                        next_tx      = full_addr[ADDR_SEL_BIT] ? lock_byte : rd_byte; // [RQ21] [RQ26]
                        next_rd_addr = look_addr + 9'd1;
                     end else if (write_enable_latch && !page_locked // [RQ14] [RQ24]
                                  && (full_addr[ADDR_SEL_BIT]
                                      ? !(snap.protect_enable_bit && !wp_s2) // [RQ16]
                                      : (full_addr[ADDR_PAGE_BIT] // [RQ12]
                                         && !(!snap.protect_mode
                                              && snap.block_protect_bits == BP_ALL)))) begin // [RQ13]
                        next_state     = ST_RX_DATA;
                        next_pg_ptr    = full_addr[7:0];
                        next_pmask     = '0;
                        next_data_seen = 1'b0;
                        next_conf      = 1'b0;
                     end else begin
                        next_state = ST_IGNORE;
                     end
                  end
               end
               ST_RX_DATA: begin
                  next_data_seen = 1'b1;
                  if (addr[ADDR_SEL_BIT]) begin
                     if (!data_seen) begin
                        next_conf = rx_next[CONF_BIT]; // [RQ19]
                     end
                  end else begin
                     pbuf_we             = 1'b1;
                     next_pmask[pg_ptr]  = 1'b1;
                     next_pg_ptr         = pg_ptr + 8'd1; // [RQ8]
                  end
               end
               ST_TX_DATA: begin
                  if (opcode == OP_STATUS_READ) begin
                     next_tx    = st_hi ? stat1 : stat0; // [RQ23]
                     next_st_hi = !st_hi;
                  end else if (opcode == READY_POLL_OP) begin
                     next_tx = poll_byte;
                  end else if (addr[ADDR_SEL_BIT]) begin
                     next_tx = lock_byte;
                  end else begin
                     next_tx      = rd_byte;
                     next_rd_addr = rd_addr + 9'd1; // [RQ11]
                  end
               end
               ST_IDLE, ST_IGNORE: begin
               end
            endcase
         end
      end else if (sck_fall && state == ST_TX_DATA) begin
         next_so      = tx_sr[7];
         next_tx      = {tx_sr[6:0], 1'b0};
         next_so_oe_b = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state              <= ST_IDLE;
         bit_cnt            <= 3'd0;
         byte_cnt           <= 2'd0;
         rx_sr              <= 8'h00;
         opcode             <= 8'h00;
         addr               <= 24'h000000;
         rd_addr            <= 9'h000;
         tx_sr              <= 8'h00;
         so                 <= 1'b0;
         so_oe_b            <= 1'b1;
         st_hi              <= 1'b0;
         pg_ptr             <= 8'h00;
         data_seen          <= 1'b0;
         conf_ok            <= 1'b0;
         snap               <= '0;
         write_enable_latch <= 1'b0;
         busy_flag          <= 1'b0;
         page_locked        <= 1'b0;
         lock_cyc           <= 1'b0;
         wr_cnt             <= 32'd0;
         word_idx           <= 7'd0;
         pmask              <= '0;
         wvalid             <= '0;
      end else begin
         state              <= next_state;
         bit_cnt            <= next_bit_cnt;
         byte_cnt           <= next_byte_cnt;
         rx_sr              <= next_rx;
         opcode             <= next_opcode;
         addr               <= next_addr;
         rd_addr            <= next_rd_addr;
         tx_sr              <= next_tx;
         so                 <= next_so;
         so_oe_b            <= next_so_oe_b;
         st_hi              <= next_st_hi;
         pg_ptr             <= next_pg_ptr;
         data_seen          <= next_data_seen;
         conf_ok            <= next_conf;
         snap               <= next_snap;
         write_enable_latch <= next_wel;
         busy_flag          <= next_busy;
         page_locked        <= next_locked;
         lock_cyc           <= next_lock_cyc;
         wr_cnt             <= next_wr_cnt;
         word_idx           <= next_word_idx;
         pmask              <= next_pmask;
         wvalid             <= next_wvalid;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   AST_POLL_BUSY: assert property ( // [RQ4]
      op_end && rx_next == READY_POLL_OP && busy_flag |=> tx_sr == POLL_BUSY)
      else $error("ready poll while busy did not load ff");
   AST_POLL_READY: assert property ( // [RQ5]
      op_end && rx_next == READY_POLL_OP && !busy_flag |=> tx_sr == POLL_READY)
      else $error("ready poll while ready did not load 00");
   AST_BUSY_IGNORE: assert property ( // [RQ6]
      op_end && busy_flag && rx_next != OP_STATUS_READ && rx_next != READY_POLL_OP
      |=> state == ST_IGNORE)
      else $error("command accepted during write cycle");
   AST_WEL_CLEAR: assert property ( // [RQ22]
      busy_flag && wr_cnt == 32'd0 |=> !write_enable_latch && !busy_flag)
      else $error("write cycle end did not clear enable latch");
   AST_LOCKED_IGNORE: assert property ( // [RQ14]
      addr_end && opcode == OP_SECURE_WRITE && page_locked |=> state == ST_IGNORE)
      else $error("secure write taken after lock");
   AST_ABORT_PARTIAL: assert property ( // [RQ15] [RQ20]
      cs_rise && state == ST_RX_DATA && bit_cnt != 3'd0 && !busy_flag |=> !busy_flag)
      else $error("write cycle started on partial byte");
   AST_LOCK_STICKS: assert property ( // [RQ17]
      page_locked |=> page_locked ##1 page_locked)
      else $error("lock state cleared");
   AST_START_NEEDS_WEL: assert property ( // [RQ24]
      $rose(busy_flag) |-> $past(write_enable_latch) && $past(cs_rise))
      else $error("write cycle started without enable or select rise");
   AST_LEGACY_BLOCK: assert property ( // [RQ13]
      addr_end && opcode == OP_SECURE_WRITE && !full_addr[ADDR_SEL_BIT] && !snap.protect_mode
      && snap.block_protect_bits == BP_ALL |=> state == ST_IGNORE)
      else $error("secure write taken with block protect set");
   AST_LOCK_WP: assert property ( // [RQ16]
      addr_end && opcode == OP_SECURE_WRITE && full_addr[ADDR_SEL_BIT]
      && snap.protect_enable_bit && !wp_s2 |=> state == ST_IGNORE)
      else $error("lock taken under hardware protection");

   COV_LOCK_DONE: cover property ($rose(page_locked));
   COV_PAGE_WRITE: cover property (mem_we);
   COV_POLL_BUSY: cover property (op_end && rx_next == READY_POLL_OP && busy_flag);
   COV_READ_WRAP: cover property (state == ST_TX_DATA && opcode == OP_SECURE_READ
                                  && $past(rd_addr) == 9'h1ff && rd_addr == 9'h000);

endmodule // secure_page_ecc_access

// ==== spi_host_model.sv ====
/*
 * Host model: serial controller driving frames, mode 0, at 16 clk_sys per bit.
 * Assumes clk_sys at 100 MHz; serial data in toggles once deselected.
 */
`timescale 1ns/100ps
module spi_host_model
   import secure_page_pkg::*;
(
   // clock
   input  wire logic clk_sys,
   // serial pins
   output spi_pins_t pins,
   input  wire logic so
);
   // ==========================================================
   // frame: n bits of tx msb first, so taken at each sck rise
   initial pins = PINS_IDLE;
   task automatic xfer(input int n, input logic [159:0] tx, output logic [159:0] rx);
      rx = '0;
      @(posedge clk_sys);
      pins.cs_b <= 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         repeat (4) @(posedge clk_sys);
         pins.si <= tx[i];
         repeat (4) @(posedge clk_sys);
         pins.sck <= 1'b1;
         rx[i] = so;
         repeat (8) @(posedge clk_sys);
         pins.sck <= 1'b0;
      end
      repeat (4) @(posedge clk_sys);
      pins.cs_b <= 1'b1;
      pins.si   <= ~pins.si;
      repeat (8) @(posedge clk_sys);
   endtask
endmodule // spi_host_model

// ==== secure_page_ecc_access_bench.sv ====
/*
 * Self-checking bench for secure_page_ecc_access with a serial host model.
 * Assumes spi_host_model and secure_page_pkg compiled before it.
 */
`timescale 1ns/100ps
module secure_page_ecc_access_bench;
   import secure_page_pkg::*;
   // ==========================================================
   // signals
   localparam logic [127:0] SN   = 128'h5e1f_00aa_c3d2_7b19_8e4f_6a20_d1c7_3b95; // arbitrary
   localparam int           WCYC = 2000;
   logic         clk_sys = 1'b0;
   logic         rst_b   = 1'b0;
   logic         wp_b    = 1'b1;
   prot_cfg_t    prot    = '0;
   spi_pins_t    spi_in;
   logic         so, so_oe_b, busy_flag, write_enable_latch, page_locked;
   int           error_cnt    = 0;
   int           total_checks = 0;
   integer       seed         = 32'h2bf62e2e;
   logic [159:0] rx;
   logic [7:0]   up [256];
   logic [8:0]   a;
   logic [7:0]   d;
   logic [31:0]  w;
   always #5 clk_sys = ~clk_sys;
   secure_page_ecc_access #(.SERIAL_NUMBER(SN), .WRITE_CYCLES(WCYC)) DUT (.clk_sys(clk_sys),
      .rst_b(rst_b), .spi_in(spi_in), .so(so), .so_oe_b(so_oe_b), .prot(prot), .wp_b(wp_b),
      .busy_flag(busy_flag), .write_enable_latch(write_enable_latch), .page_locked(page_locked));
   // a released output shows the inverse, so a late or missing drive enable is caught
   spi_host_model host (.clk_sys(clk_sys), .pins(spi_in), .so(so_oe_b ? ~so : so));
   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done;
      if (error_cnt == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   function automatic logic [7:0] exp_b(input logic [8:0] ad);
      return ad[8] ? up[ad[7:0]] : (ad < 16 ? SN[127-8*int'(ad) -: 8] : 8'h00);
   endfunction
   task automatic rd(input logic a10, input logic [8:0] ad, input int k);
      host.xfer(32 + 8*k, {128'h0, OP_SECURE_READ, 13'h0, a10, 1'b0, ad} << (8*k), rx);
   endtask
   task automatic wr(input logic lk, input logic [8:0] ad, input logic [7:0] dt, input int n);
      logic [159:0] v;
      v = {120'h0, OP_SECURE_WRITE, 13'h0, lk, 1'b0, ad, dt};
      host.xfer(n, n >= 40 ? v << (n - 40) : v >> (40 - n), rx);
   endtask
   task automatic poll(input logic [7:0] op);
      host.xfer(16, {op, 8'h00}, rx);
   endtask
   // ==========================================================
   // main sequence
   initial begin
      foreach (up[i]) up[i] = 8'hff;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk("reset", {busy_flag, write_enable_latch, page_locked, so_oe_b}, 4'b0001);
      rd(1'b0, 9'h000, 16);
      chk("serial", rx[127:0], SN);
      rd(1'b0, 9'h010, 1);
      chk("reserved", rx[7:0], exp_b(9'h010));
      rd(1'b1, 9'h000, 1);
      chk("unlocked", rx[0], 1'b0);
      wr(1'b0, 9'h140, 8'h5a, 40);
      chk("no_enable", busy_flag, 1'b0);
      host.xfer(8, OP_WRITE_ENABLE, rx);
      chk("wel", write_enable_latch, 1'b1);
      wr(1'b0, 9'h040, 8'h5a, 40);
      chk("lower", busy_flag, 1'b0);
      wr(1'b0, 9'h140, 8'h5a, 43);
      chk("off_byte", busy_flag, 1'b0);
      prot.block_protect_bits <= BP_ALL;
      wr(1'b0, 9'h140, 8'h5a, 40);
      chk("bp_block", busy_flag, 1'b0);
      prot <= '0;
      for (int i = 0; i < 3; i++) begin
         a = (i == 0) ? 9'h1ff : {1'b1, 8'($random(seed))};
         d = 8'($random(seed));
         host.xfer(8, OP_WRITE_ENABLE, rx);
         wr(1'b0, a, d, 40);
         chk("busy", busy_flag, 1'b1);
         up[a[7:0]] = d;
         poll(OP_READY_POLL);
         chk("poll_busy", rx[7:0], POLL_BUSY);
         poll(OP_STATUS_READ);
         chk("stat_busy", rx[1:0], 2'b11);
         wr(1'b1, 9'h000, 8'h02, 40); // ignored while busy
         repeat (WCYC) @(posedge clk_sys);
         poll(OP_READY_POLL);
         chk("poll_rdy", rx[7:0], POLL_READY);
         chk("wel_clr", {write_enable_latch, page_locked}, 2'b00);
         rd(1'b0, a, 1);
         chk("readback", rx[7:0], d);
         // whole word: the three neighbours must survive the byte write
         for (int j = 0; j < 4; j++) begin
            w = {w[23:0], exp_b({a[8:2], 2'(j)})};
         end
         rd(1'b0, {a[8:2], 2'b00}, 4);
         chk("word", rx[31:0], w);
      end
      rd(1'b0, 9'h1ff, 2);
      chk("wrap", rx[15:0], {exp_b(9'h1ff), exp_b(9'h000)});
      host.xfer(8, OP_WRITE_ENABLE, rx);
      prot.protect_enable_bit <= 1'b1;
      wp_b <= 1'b0;
      wr(1'b1, 9'h000, 8'h02, 40);
      chk("lock_wp", busy_flag, 1'b0);
      prot <= '0;
      wp_b <= 1'b1;
      wr(1'b1, 9'h000, 8'h02, 32);
      chk("lock_short", busy_flag, 1'b0);
      wr(1'b1, 9'h000, 8'h02, 40);
      chk("lock_busy", busy_flag, 1'b1);
      repeat (WCYC) @(posedge clk_sys);
      chk("locked", page_locked, 1'b1);
      rd(1'b1, 9'h000, 1);
      chk("lock_chk", rx[0], 1'b1);
      host.xfer(8, OP_WRITE_ENABLE, rx);
      wr(1'b0, a, ~d, 40);
      chk("lock_wr", busy_flag, 1'b0);
      rd(1'b0, a, 1);
      chk("kept", rx[7:0], d);
      test_done();
   end
   // tests take about 32,000 cycles; give up at about twice that
   initial begin
      #640_000;
      error_cnt++;
      test_done();
   end
endmodule // secure_page_ecc_access_bench
